// File: dv/mia_arbiter_sva.sv
// Port checker for the interrupt arbiter
`timescale 1ns/1ps
module mia_arbiter_sva (
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic [7:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire mia_pkg::mia_core_t core_in,
  input wire mia_pkg::mia_call_t call_out,
  input wire logic               timer_a_irq_ack,
  input wire logic               timer_b_irq_ack
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic ge_q;
  // Shadow of the global enable; the bench always writes all lanes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ge_q <= 1'b0;
    else if (avs_write && avs_address == 8'h00) ge_q <= avs_writedata[7];
  end
  // ----------
  // Properties
  // ----------
  property p_vec; call_out.valid |-> call_out.vector == 16'h0003 + {call_out.source, 3'h0}; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_src; call_out.valid |-> call_out.source < 4'hB; endproperty
  a_src: assert property (p_src) else $error("bad source");
  property p_hold; $rose(call_out.valid) |=> (call_out.valid && $stable(call_out.vector))[*5]; endproperty
  a_hold: assert property (p_hold) else $error("call too short");
  property p_tmr; timer_a_irq_ack |=> call_out.valid && call_out.source == 4'h2 && !timer_a_irq_ack; endproperty
  a_tmr: assert property (p_tmr) else $error("bad timer ack");
  property p_tmb; timer_b_irq_ack |=> call_out.valid && call_out.source == 4'h6 && !timer_b_irq_ack; endproperty
  a_tmb: assert property (p_tmb) else $error("bad second timer ack");
  property p_gen; $rose(call_out.valid) |-> $past(ge_q); endproperty
  a_gen: assert property (p_gen) else $error("call while disabled");
  property p_blk; core_in.ret_exec || core_in.cfg_write || (avs_write && avs_address <= 8'h10)
    |=> !$rose(call_out.valid); endproperty
  a_blk: assert property (p_blk) else $error("call not withheld");
  property p_en3; avs_read && avs_address == 8'h08 |=> avs_readdata[31:1] == 31'h0; endproperty
  a_en3: assert property (p_en3) else $error("third enable bits");
  property p_en1; avs_read && avs_address == 8'h00 |=> !avs_readdata[5] && avs_readdata[31:8] == 24'h0; endproperty
  a_en1: assert property (p_en1) else $error("first enable bits");
  // Main scenarios reached
  c_tmr: cover property (timer_a_irq_ack);
  c_top: cover property ($rose(call_out.valid) && call_out.level == 2'h3);
  c_ret: cover property (core_in.ret_exec ##[1:8] $rose(call_out.valid));
endmodule // mia_arbiter_sva
bind mia_arbiter mia_arbiter_sva i_sva (.clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .core_in, .call_out, .timer_a_irq_ack, .timer_b_irq_ack);

// File: dv/mia_core_model.sv
// Core sequencer model that ends each forced call
`timescale 1ns/1ps
module mia_core_model (
  input wire logic               clock,
  input wire logic               rstn,
  input wire mia_pkg::mia_call_t call_out,
  input wire logic               slow,
  output logic                   call_done
);
  logic [3:0] cnt_q;
  // Count call cycles; slow mode stretches past the minimum
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) cnt_q <= 4'h0;
    else cnt_q <= call_out.valid ? cnt_q + 4'h1 : 4'h0;
  end
  // Never end a call before its sixth cycle
  assign call_done = call_out.valid && cnt_q == (slow ? 4'h9 : 4'h5);
endmodule // mia_core_model

// File: dv/test_mia_arbiter.sv
// Self-checking bench for the interrupt arbiter
`timescale 1ns/1ps
`include "mia_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module test_mia_arbiter;
  logic clock = 1'b0, rstn = 1'b0, rd_en = 1'b0, wr_en = 1'b0, wd = 1'b0, slow = 1'b0;
  logic call_done, wait_req, ack_a, ack_b;
  logic [7:0] adr = 8'h00, lo, hi, offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
  logic [7:0] msks [6] = '{`MIA_IEN_FIRST_MASK, `MIA_IEN_SECOND_MASK, `MIA_IEN_THIRD_MASK, `MIA_PRIO_MASK,
                           `MIA_PRIO_MASK, 8'h00};
  logic [31:0] wdat = 32'h0, rdat, rd, rng = 32'h3C;
  logic [10:0] evt = 11'h0;
  logic [15:0] l;
  mia_pkg::mia_core_t core_q = 3'h1;
  mia_pkg::mia_call_t call_out;
  int a, b, w, v, miscompares = 0, check_count = 0;
  mia_arbiter i_dut (.clock, .rstn, .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wait_req), .src_event(evt),
    .watchdog_started_flag(wd), .core_in(core_q), .call_done, .call_out, .timer_a_irq_ack(ack_a),
    .timer_b_irq_ack(ack_b));
  mia_core_model i_core (.clock, .rstn, .call_out, .slow, .call_done);
  // Free-running 50 MHz clock
  always #10 clock = ~clock;
  // ---------------------
  // Expectation functions
  // ---------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [15:0] loc(int s);
    if (s == 1) return 16'h0801;
    if (s == 10) return 16'h0420;
    return {(s % 2) ? 8'h04 : 8'h00, 8'h01 << (s / 2)};
  endfunction
  function automatic logic [7:0] full(logic [7:0] x);
    return x == 8'h00 ? `MIA_IEN_FIRST_MASK : x == 8'h04 ? `MIA_IEN_SECOND_MASK : `MIA_IEN_THIRD_MASK;
  endfunction
  // -------------
  // Drivers and checkers
  // -------------
  task automatic bus(input logic [7:0] x, input logic wr, input logic [31:0] d);
    adr <= x; rd_en <= ~wr; wr_en <= wr; wdat <= d;
    @(posedge clock);
    while (wait_req) @(posedge clock);
    rd = rdat;
    rd_en <= 1'b0; wr_en <= 1'b0;
    @(posedge clock);
  endtask
  // Global enable is written last so masking never opens early
  task automatic en(input logic [7:0] e0, e1, e2);
    bus(8'h08, 1'b1, {24'h0, e2}); bus(8'h04, 1'b1, {24'h0, e1}); bus(8'h00, 1'b1, {24'h0, e0});
  endtask
  task automatic pulse(input logic [10:0] m);
    evt <= m; @(posedge clock); evt <= 11'h0;
  endtask
  task automatic ret();
    core_q <= 3'h5; @(posedge clock); core_q <= 3'h1; @(posedge clock);
  endtask
  task automatic quiet();
    bit seen = 1'b0;
    repeat (14) begin @(posedge clock); seen |= call_out.valid === 1'b1; end
    `CHK(seen, 1'b0)
  endtask
  task automatic wait_call(input int s, input logic [1:0] lv);
    int n = 0;
    while (call_out.valid !== 1'b1 && n < 40) begin @(posedge clock); n++; end
    `CHK(call_out.valid, 1'b1)
    `CHK(call_out.source, s[3:0])
    `CHK(call_out.vector, `MIA_VEC_BASE + 16'(s) * `MIA_VEC_STEP)
    `CHK(call_out.level, lv)
    while (call_out.valid === 1'b1 && n < 80) begin @(posedge clock); n++; end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin #600000; miscompares++; conclude(); end
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    foreach (offs[i]) begin
      bus(offs[i], 1'b0, 32'h0); `CHK(rd, 32'h0)
      bus(offs[i], 1'b1, 32'hFF); bus(offs[i], 1'b0, 32'h0); `CHK(rd, {24'h0, msks[i]})
    end
    wd <= 1'b1; @(posedge clock);
    bus(8'h0C, 1'b0, 32'h0); `CHK(rd, 32'h7F)
    bus(8'h0C, 1'b1, 32'h0); bus(8'h10, 1'b1, 32'h0);
    $display("register test done");
    for (int s = 0; s < 11; s++) begin
      l = loc(s);
      en(8'h5F, 8'h7E, 8'h01); pulse(11'h1 << s); quiet();
      bus(8'h14, 1'b0, 32'h0); `CHK(rd[s], 1'b1)
      en(full(8'h00) & ~(l[15:8] == 8'h00 ? l[7:0] : 8'h00), full(8'h04) & ~(l[15:8] == 8'h04 ? l[7:0] : 8'h00),
         full(8'h08) & ~(l[15:8] == 8'h08 ? l[7:0] : 8'h00)); quiet();
      bus(l[15:8], 1'b1, {24'h0, full(l[15:8])}); wait_call(s, 2'h0);
      bus(8'h14, 1'b1, 32'h7FF); ret();
    end
    $display("mask test done");
    for (int k = 0; k < 60; k++) begin
      a = xs() % 11; b = (a + 1 + xs() % 10) % 11; lo = 8'(xs()); hi = 8'(xs()); slow <= xs() % 2;
      bus(8'h0C, 1'b1, {24'h0, lo}); bus(8'h10, 1'b1, {24'h0, hi});
      w = ({hi[a/2], lo[a/2]} > {hi[b/2], lo[b/2]} || ({hi[a/2], lo[a/2]} == {hi[b/2], lo[b/2]} && a < b)) ? a : b;
      v = (w == a) ? b : a;
      pulse((11'h1 << a) | (11'h1 << b)); wait_call(w, {hi[w/2], lo[w/2]});
      bus(8'h14, 1'b0, 32'h0); `CHK(rd[w], w != 2 && w != 6)
      bus(8'h14, 1'b1, 32'h1 << w); quiet();
      ret(); wait_call(v, {hi[v/2], lo[v/2]});
      bus(8'h14, 1'b1, 32'h7FF); ret();
    end
    $display("priority test done");
    conclude();
  end
endmodule // test_mia_arbiter

// File: inc/mia_map.svh
// Register map, field positions and timing counts of the interrupt arbiter
// ---------------------------------------------------------------------------
// Operation
// - Eleven sources, four priority levels
// - Each source masked by own enable bit
// - Flag sets regardless of enable
// - Sample flags each machine cycle, poll samples
// - Next cycle acknowledge with forced vector call
// - Withhold while equal/higher level active
// - Withhold during return or enable/priority write
// - Preempt only by strictly higher level
// - Return ends current service level
// - Latency at least seven machine cycles
// - Global enable bit seven blocks all
// - First enable register source bits
// - Second enable register bits five..one
// - Third enable register bit zero
// - Watchdog bits never mask; bit five unused
// - Watchdog started status in priority register
// - Six groups, level from two registers
// - Fixed polling order breaks ties
// - Timer flags cleared on service entry
// ---------------------------------------------------------------------------
`ifndef MIA_MAP_SVH
`define MIA_MAP_SVH

// ---------------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------------
`define MIA_OFS_IEN_FIRST   8'h00
`define MIA_OFS_IEN_SECOND  8'h04
`define MIA_OFS_IEN_THIRD   8'h08
`define MIA_OFS_PRIO_LOW    8'h0C
`define MIA_OFS_PRIO_HIGH   8'h10
`define MIA_OFS_FLAGS       8'h14
`define MIA_OFS_STATUS      8'h18

// ---------------------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------------------
`define MIA_BIT_GLOBAL      7
`define MIA_BIT_WD_STARTED  6
`define MIA_IEN_FIRST_MASK  8'hDF
`define MIA_IEN_SECOND_MASK 8'h7E
`define MIA_IEN_THIRD_MASK  8'h01
`define MIA_PRIO_MASK       8'h3F
`define MIA_RESET_BYTE      8'h00

// ---------------------------------------------------------------------------
// Timing and call vectors
// ---------------------------------------------------------------------------
`define MIA_CALL_CYCLES     3'h6
`define MIA_VEC_BASE        16'h0003
`define MIA_VEC_STEP        16'h0008

`endif

// File: inc/mia_pkg.sv
// Types shared by the interrupt arbiter
package mia_pkg;
  // Source indices in fixed polling order, index 0 polled first
  typedef enum logic [3:0] {
    MIA_SRC_EXT0, MIA_SRC_SER_B, MIA_SRC_TMR_A, MIA_SRC_EXT2, MIA_SRC_EXT1, MIA_SRC_EXT3,
    MIA_SRC_TMR_B, MIA_SRC_EXT4, MIA_SRC_SER_A, MIA_SRC_EXT5, MIA_SRC_EXT6
  } mia_src_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
    logic [1:0]  level;
    logic [3:0]  source;
  } mia_call_t;

  typedef struct packed {
    logic ret_exec;
    logic cfg_write;
    logic instr_busy;
  } mia_core_t;
endpackage

// File: rtl/mia_arbiter.sv
// Interrupt arbiter with enable and priority registers on Avalon-MM
`timescale 1ns/1ps
`include "mia_map.svh"
module mia_arbiter (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [10:0]           src_event,
  input  wire logic                  watchdog_started_flag,
  input  wire mia_pkg::mia_core_t    core_in,
  input  wire logic                  call_done,
  output mia_pkg::mia_call_t         call_out,
  output logic                       timer_a_irq_ack,
  output logic                       timer_b_irq_ack
);

  // -------------------------------------------------------------------------
  // Timing overview
  // -------------------------------------------------------------------------
  // One clock here stands for one machine cycle of the core.
  // Event at edge n sets its flag at n, the sample is taken at n+1,
  // and the take decision is combinational in the cycle after the sample.
  // The forced call then stands on call_out for at least six cycles;
  // the core ends it with call_done once the six cycles are over.
  // Timer flags are cleared by the same take that starts their call.
  // Reads insert one wait state so that read data come from a flop
  // and still stand at the edge where waitrequest is seen low.
  // Writes complete at once; a write to any enable or priority
  // register also holds off an acknowledge in that cycle.
  // Limitation: only one call is in flight; a later request waits
  // until the core has ended the current call.
  // Trade-off: a level is one bit of active_q, so a nested call of the
  // same level can never be recorded, which matches the rule that equal
  // levels never preempt each other.

  // -------------------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------------------
  logic [7:0]  ien_first_q;        // First enable register
  logic [7:0]  ien_second_q;       // Second enable register
  logic [7:0]  ien_third_q;        // Third enable register
  logic [7:0]  prio_low_q;         // Low priority select bits
  logic [7:0]  prio_high_q;        // High priority select bits
  logic [10:0] flag_q;             // Request flags
  logic [10:0] sample_q;           // Flags as sampled each cycle
  logic        rd_ready_q;         // Read data loaded, answer now
  logic [3:0]  active_q;           // One bit per level in service
  logic        wd_started_q;
  logic        ack_q;
  logic [2:0]  call_cnt_q;
  logic [31:0] rdata_q;
  mia_pkg::mia_call_t call_q;
  logic [10:0] enabled;            // Enable per source after global gate
  logic [10:0] pend;               // Sampled and enabled requests
  logic [10:0] clr_sw;             // Software clear strobes
  logic [1:0]  src_level [11];
  logic [1:0]  best_level;
  logic [3:0]  best_src;
  logic        best_valid;         // Some request is pending
  logic        cfg_hit;            // Enable or priority write this cycle
  logic        take;               // Acknowledge this cycle
  logic        core_ok;            // Core state allows acknowledge
  logic        cfg_ok;             // No configuration write in progress
  logic        idle_ok;            // No call in flight
  logic        call_end;           // Core ends the current call

  // Group of each source, used for priority lookup
  function automatic logic [2:0] group_of(input logic [3:0] s);
    case (s)
      4'h0, 4'h1: group_of = 3'h0;
      4'h2, 4'h3: group_of = 3'h1;
      4'h4, 4'h5: group_of = 3'h2;
      4'h6, 4'h7: group_of = 3'h3;
      4'h8, 4'h9: group_of = 3'h4;
      default:    group_of = 3'h5;
    endcase
  endfunction

  // Highest active level, 3'h4 coded as none
  function automatic logic [2:0] top_active(input logic [3:0] a);
    if (a[3])      top_active = 3'h3;
    else if (a[2]) top_active = 3'h2;
    else if (a[1]) top_active = 3'h1;
    else if (a[0]) top_active = 3'h0;
    else           top_active = 3'h4;
  endfunction

  // -------------------------------------------------------------------------
  // Bus slave: writes single cycle, reads one wait state
  // -------------------------------------------------------------------------
  wire wr_lane0 = avs_write && avs_byteenable[0];
  // Registered read data must stand when waitrequest drops
  assign avs_waitrequest = avs_read && !rd_ready_q;
  assign avs_readdata    = rdata_q;
  // Any write to enable or priority registers defers acknowledge
  assign cfg_hit = core_in.cfg_write ||
                   (wr_lane0 && (avs_address <= `MIA_OFS_PRIO_HIGH));

  // Enable and priority registers; unused bits stay zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ien_first_q  <= `MIA_RESET_BYTE;
      ien_second_q <= `MIA_RESET_BYTE;
      ien_third_q  <= `MIA_RESET_BYTE;
      prio_low_q   <= `MIA_RESET_BYTE;
      prio_high_q  <= `MIA_RESET_BYTE;
    end else if (wr_lane0) begin
      case (avs_address)
        `MIA_OFS_IEN_FIRST:  ien_first_q  <= avs_writedata[7:0] & `MIA_IEN_FIRST_MASK;
        `MIA_OFS_IEN_SECOND: ien_second_q <= avs_writedata[7:0] & `MIA_IEN_SECOND_MASK;
        `MIA_OFS_IEN_THIRD:  ien_third_q  <= avs_writedata[7:0] & `MIA_IEN_THIRD_MASK;
        `MIA_OFS_PRIO_LOW:   prio_low_q   <= avs_writedata[7:0] & `MIA_PRIO_MASK;
        `MIA_OFS_PRIO_HIGH:  prio_high_q  <= avs_writedata[7:0] & `MIA_PRIO_MASK;
        default: ;
      endcase
    end
  end

  // Read wait state: high for the cycle after a read is first seen
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_ready_q <= 1'b0;
    end else begin
      rd_ready_q <= avs_read && !rd_ready_q;
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
    end else if (avs_read && !rd_ready_q) begin
      case (avs_address)
        `MIA_OFS_IEN_FIRST:  rdata_q <= {24'h0, ien_first_q};
        `MIA_OFS_IEN_SECOND: rdata_q <= {24'h0, ien_second_q};
        `MIA_OFS_IEN_THIRD:  rdata_q <= {24'h0, ien_third_q};
        `MIA_OFS_PRIO_LOW:   rdata_q <= {24'h0, 1'b0, wd_started_q, prio_low_q[5:0]};
        `MIA_OFS_PRIO_HIGH:  rdata_q <= {24'h0, prio_high_q};
        `MIA_OFS_FLAGS:      rdata_q <= {21'h0, flag_q};
        `MIA_OFS_STATUS:     rdata_q <= {27'h0, ack_q, active_q};
        default:             rdata_q <= 32'h0;
      endcase
    end
  end

  // Watchdog started status, cleared only by reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) wd_started_q <= 1'b0;
    else if (watchdog_started_flag) wd_started_q <= 1'b1;
  end

  // -------------------------------------------------------------------------
  // Flags: set by event regardless of enable; set beats clear
  // -------------------------------------------------------------------------
  // Writing one to a flag bit clears it
  assign clr_sw = (avs_write && avs_byteenable[0] && avs_address == `MIA_OFS_FLAGS) ?
                  {avs_byteenable[1] ? avs_writedata[10:8] : 3'h0, avs_writedata[7:0]} : 11'h0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 11'h0;
    end else begin
      for (int i = 0; i < 11; i++) begin
        if (src_event[i]) flag_q[i] <= 1'b1;
        else if (clr_sw[i] || (take && best_src == 4'(i) &&
                 (i == 2 || i == 6))) flag_q[i] <= 1'b0;
      end
    end
  end

  // Per-source enable mapping
  always_comb begin
    enabled = '0;
    enabled[mia_pkg::MIA_SRC_EXT0]  = ien_first_q[0];
    enabled[mia_pkg::MIA_SRC_TMR_A] = ien_first_q[1];
    enabled[mia_pkg::MIA_SRC_EXT1]  = ien_first_q[2];
    enabled[mia_pkg::MIA_SRC_TMR_B] = ien_first_q[3];
    enabled[mia_pkg::MIA_SRC_SER_A] = ien_first_q[4];
    enabled[mia_pkg::MIA_SRC_EXT2]  = ien_second_q[1];
    enabled[mia_pkg::MIA_SRC_EXT3]  = ien_second_q[2];
    enabled[mia_pkg::MIA_SRC_EXT4]  = ien_second_q[3];
    enabled[mia_pkg::MIA_SRC_EXT5]  = ien_second_q[4];
    enabled[mia_pkg::MIA_SRC_EXT6]  = ien_second_q[5];
    enabled[mia_pkg::MIA_SRC_SER_B] = ien_third_q[0];
    if (!ien_first_q[`MIA_BIT_GLOBAL]) enabled = '0;
  end

  // Sample once per machine cycle (one clock here)
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) sample_q <= 11'h0;
    else sample_q <= flag_q;
  end

  assign pend = sample_q & enabled;

  // Level of each source from its group bits
  genvar g;
  generate
    for (g = 0; g < 11; g++) begin : g_level
      assign src_level[g] = {prio_high_q[group_of(4'(g))], prio_low_q[group_of(4'(g))]};
    end
  endgenerate

  // Highest level wins; lowest index wins among equals
  always_comb begin
    best_valid = 1'b0;
    best_level = 2'h0;
    best_src   = 4'h0;
    for (int i = 0; i < 11; i++) begin
      if (pend[i] && (!best_valid || src_level[i] > best_level)) begin
        best_valid = 1'b1;
        best_level = src_level[i];
        best_src   = 4'(i);
      end
    end
  end

  // -------------------------------------------------------------------------
  // Acknowledge and forced call
  // -------------------------------------------------------------------------
  wire [2:0] cur_top = top_active(active_q);
  wire       beats   = (cur_top == 3'h4) || ({1'b0, best_level} > cur_top);
  // Core must be mid-instruction and not returning
  assign core_ok  = core_in.instr_busy && !core_in.ret_exec;
  // Enable and priority writes from either side defer the acknowledge
  assign cfg_ok   = !cfg_hit;
  // Only one forced call in flight at a time
  assign idle_ok  = !ack_q;
  assign take     = best_valid && beats && idle_ok && core_ok && cfg_ok;
  // A done pulse before the sixth cycle is ignored
  assign call_end = ack_q && (call_cnt_q <= 3'h1) && call_done;

  // Acknowledge busy from take until the core ends the call
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else if (take) begin
      ack_q <= 1'b1;
    end else if (call_end) begin
      ack_q <= 1'b0;
    end
  end

  // Call cycle counter: six cycles before an end is accepted
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      call_cnt_q <= 3'h0;
    end else if (take) begin
      call_cnt_q <= `MIA_CALL_CYCLES;
    end else if (ack_q && call_cnt_q > 3'h1) begin
      call_cnt_q <= call_cnt_q - 3'h1;
    end else if (call_end) begin
      call_cnt_q <= 3'h0;
    end
  end

  // Call request: vector, level and source held for the whole call
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      call_q <= '0;
    end else if (take) begin
      call_q.valid  <= 1'b1;
      call_q.level  <= best_level;
      call_q.source <= best_src;
      call_q.vector <= `MIA_VEC_BASE + 16'(best_src) * `MIA_VEC_STEP;
    end else if (call_end) begin
      call_q.valid  <= 1'b0;
    end
  end

  // Levels in service: set on take, top cleared on return
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      active_q <= 4'h0;
    end else if (take) begin
      active_q[best_level] <= 1'b1;
    end else if (core_in.ret_exec && cur_top != 3'h4) begin
      active_q[cur_top[1:0]] <= 1'b0;
    end
  end

  assign call_out        = call_q;
  assign timer_a_irq_ack = take && best_src == 4'(mia_pkg::MIA_SRC_TMR_A);
  assign timer_b_irq_ack = take && best_src == 4'(mia_pkg::MIA_SRC_TMR_B);

endmodule // mia_arbiter
